// ---- rtl/pom_top.sv ----
// output macrocells with enable terms, polarity, preload and register bus
//
// How it works
// - each output enable comes from its own product term of inputs and feedback.
// - a combinational output pin is bidirectional, a pure input when never enabled.
// - a per-output polarity bit applies to registered and combinational outputs alike.
// - polarity bit one drives the uninverted value, active high.
// - one set term and one clear term serve every output register.
// - set term high loads ones into all registers at the next rising edge, unless preload or the clear term is active.
// - clear term high forces all registers to zero at once, no clock needed.
// - set and clear act on flops; a registered cell's pin shows them through its polarity.
// - power-up clears all flops; pins then follow their polarity.
// - once secured, pattern readback shows every location as all ones.
// - super-level on the preload pin enters preload and disables all outputs.
// - in preload the tester drives registered pins, leaves combinational ones floating.
// - a rising clock in preload loads each register from its pin.
// - flops must not glitch when setup or hold is violated.
//
// Added by the designer: register access over Avalon-MM and the address map.
`timescale 1ns/100ps
module pom_top (
    input wire logic clock_i,                          // device clock, 20 MHz
    input wire logic rstn_i,                           // sync reset, active low
    input wire logic [7:0] avs_address_i,              // byte address
    input wire logic avs_read_i,                       // read request
    input wire logic avs_write_i,                      // write request
    input wire logic [31:0] avs_writedata_i,           // write data
    input wire logic [3:0] avs_byteenable_i,           // byte lanes
    output logic [31:0] avs_readdata_o,                // read data
    output logic avs_waitrequest_o,                    // stall, high until answered
    input wire logic [pom_pkg::N_IN-1:0] in_pin_i,     // dedicated input pins
    input wire logic [pom_pkg::N_OUT-1:0] io_pin_i,    // level seen on the output pins
    output logic [pom_pkg::N_OUT-1:0] io_pin_o,        // value driven on the output pins
    output logic [pom_pkg::N_OUT-1:0] io_oe_o,         // high while a pin is driven
    input wire logic preload_hv_i,                     // super-level detector on the preload pin
    input wire logic [pom_pkg::N_OUT-1:0] eq_i,        // sum terms from the array
    input wire logic shared_sync_set_term_i,           // array set term
    input wire logic shared_async_clear_term_i         // array clear term
);

    // pin synchronisers

    logic [pom_pkg::N_SYNC-1:0] sync1_reg;
    logic [pom_pkg::N_SYNC-1:0] sync2_reg;
    logic [pom_pkg::N_IN-1:0] in_s;
    logic [pom_pkg::N_OUT-1:0] io_s;
    logic preload_s;

    // a late pin edge only ever delays the flop by a clock, never glitches it
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {preload_hv_i, io_pin_i, in_pin_i};
            sync2_reg <= sync1_reg;
        end
    end

    assign in_s = sync2_reg[pom_pkg::N_IN-1:0];
    assign io_s = sync2_reg[pom_pkg::N_LIT-1:pom_pkg::N_IN];
    assign preload_s = sync2_reg[pom_pkg::N_SYNC-1];

    // two edges from pin to logic; an input seen one edge early would risk metastability
    a_sync_pipe: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (rstn_i && $past(rstn_i) && $past(rstn_i, 2))
        |-> sync2_reg == $past({preload_hv_i, io_pin_i, in_pin_i}, 2))
        else $error("pin synchroniser depth wrong");

    // configuration state

    logic [pom_pkg::N_OUT-1:0] polarity_select_bit_reg;
    logic [pom_pkg::N_OUT-1:0] reg_mode_reg;
    logic secure_reg;
    logic [pom_pkg::N_LIT-1:0] pat_reg [pom_pkg::PAT_WORDS];

    // bus handshake

    logic wait_n_reg;
    logic req;
    logic wr_take;
    logic rd_take;
    logic [31:0] be_mask;
    logic [7:0] pat_off;
    logic [pom_pkg::PAT_IW-1:0] pat_idx;
    logic pat_hit;
    logic [31:0] rd_next;

    assign req = avs_read_i | avs_write_i;
    // write takes effect on the edge where waitrequest is sampled low
    assign wr_take = avs_write_i & ~wait_n_reg;
    assign rd_take = avs_read_i & wait_n_reg;
    assign be_mask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                      {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    assign pat_off = avs_address_i - pom_pkg::A_PAT;
    assign pat_idx = pat_off[pom_pkg::PAT_IW+1:2];
    assign pat_hit = (avs_address_i >= pom_pkg::A_PAT)
                   && (avs_address_i < pom_pkg::A_PAT_END)
                   && (avs_address_i[1:0] == 2'h0);

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] mask);
        merge = (old & ~mask) | (wd & mask);
    endfunction : merge

    // one wait cycle per access: low for exactly one edge, then high again
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            wait_n_reg <= 1'b1;
        end else begin
            wait_n_reg <= ~(req & wait_n_reg);
        end
    end

    assign avs_waitrequest_o = wait_n_reg;

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            polarity_select_bit_reg <= pom_pkg::POL_RST;
            reg_mode_reg <= pom_pkg::MODE_RST;
        end else if (wr_take && avs_address_i == pom_pkg::A_POL) begin
            polarity_select_bit_reg <= pom_pkg::N_OUT'(merge(
                32'(polarity_select_bit_reg), avs_writedata_i, be_mask));
        end else if (wr_take && avs_address_i == pom_pkg::A_MODE) begin
            reg_mode_reg <= pom_pkg::N_OUT'(merge(
                32'(reg_mode_reg), avs_writedata_i, be_mask));
        end
    end

    // the security fuse can only be blown, never restored short of power-up
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            secure_reg <= 1'b0;
        end else if (wr_take && avs_address_i == pom_pkg::A_SEC
                     && avs_byteenable_i[0]
                     && avs_writedata_i[pom_pkg::SEC_BIT]) begin
            secure_reg <= 1'b1;
        end
    end

    // enable-term pattern: even word is the care mask, odd word the match value
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            for (int k = 0; k < pom_pkg::PAT_WORDS; k++) begin
                pat_reg[k] <= pom_pkg::PAT_RST;
            end
        end else if (wr_take && pat_hit) begin
            pat_reg[pat_idx] <= pom_pkg::N_LIT'(merge(
                32'(pat_reg[pat_idx]), avs_writedata_i, be_mask));
        end
    end

    // register bank and its wiring

    pom_mc_if mc ();

    pom_oreg u_oreg (
        .clock_i (clock_i),
        .rstn_i (rstn_i),
        .m (mc.core)
    );

    assign mc.ar = shared_async_clear_term_i;
    assign mc.sp = shared_sync_set_term_i;
    assign mc.preload = preload_s;
    assign mc.eq = eq_i;
    assign mc.pin = io_s;

    // read mux

    logic [31:0] stat_word;
    logic [31:0] pin_word;

    always_comb begin
        stat_word = pom_pkg::RD_ZERO;
        stat_word[pom_pkg::N_OUT-1:0] = mc.q;
        stat_word[pom_pkg::ST_PRE_BIT] = preload_s;
        pin_word = pom_pkg::RD_ZERO;
        pin_word[pom_pkg::N_OUT-1:0] = io_s;
        pin_word[pom_pkg::PIN_IN_LSB+pom_pkg::N_IN-1:pom_pkg::PIN_IN_LSB] = in_s;
    end

    always_comb begin
        rd_next = pom_pkg::RD_ZERO;
        if (pat_hit) begin
            if (secure_reg) begin
                rd_next = 32'(pom_pkg::PAT_ONES);
            end else begin
                rd_next = 32'(pat_reg[pat_idx]);
            end
        end else begin
            case (avs_address_i)
                pom_pkg::A_POL: rd_next = 32'(polarity_select_bit_reg);
                pom_pkg::A_MODE: rd_next = 32'(reg_mode_reg);
                pom_pkg::A_SEC: rd_next = 32'(secure_reg);
                pom_pkg::A_STAT: rd_next = stat_word;
                pom_pkg::A_PIN: rd_next = pin_word;
                default: rd_next = pom_pkg::RD_ZERO;
            endcase
        end
    end

    // data is latched on the taking edge so it stands while waitrequest is low
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            avs_readdata_o <= pom_pkg::RD_ZERO;
        end else if (rd_take) begin
            avs_readdata_o <= rd_next;
        end
    end

    // enable product terms

    logic [pom_pkg::N_OUT-1:0] feedback;
    logic [pom_pkg::N_LIT-1:0] lits;
    logic [pom_pkg::N_OUT-1:0] oe_term;

    // combinational cells feed back the pin, so they work as inputs too
    assign feedback = (reg_mode_reg & mc.q) | (~reg_mode_reg & io_s);
    assign lits = {feedback, in_s};

    // an empty care mask is an unprogrammed term: it stays false
    for (genvar g = 0; g < pom_pkg::N_OUT; g++) begin : g_oe
        logic [pom_pkg::N_LIT-1:0] care;
        logic [pom_pkg::N_LIT-1:0] val;
        assign care = pat_reg[2*g];
        assign val = pat_reg[2*g+1];
        assign oe_term[g] = (|care) && ((lits & care) == (val & care));
        a_oe_unprog: assert property (@(posedge clock_i) disable iff (!rstn_i)
            (care == '0) |=> !io_oe_o[g])
            else $error("output enabled by an empty term");
    end

    // pin drivers

    logic [pom_pkg::N_OUT-1:0] cell_val;
    logic [pom_pkg::N_OUT-1:0] drive_val;

    assign cell_val = (reg_mode_reg & mc.q) | (~reg_mode_reg & eq_i);
    // polarity one passes the value straight, zero inverts it
    assign drive_val = cell_val ^ ~polarity_select_bit_reg;

    // pins are registered, so they trail the cell value by one clock
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            io_pin_o <= '0;
            io_oe_o <= '0;
        end else begin
            io_pin_o <= drive_val;
            io_oe_o <= preload_s ? '0 : oe_term;
        end
    end

    // checks

    a_oe_preload: assert property (@(posedge clock_i) disable iff (!rstn_i)
        preload_s |=> io_oe_o == '0)
        else $error("output driven during preload");

    a_oe_term: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !preload_s |=> io_oe_o == $past(oe_term))
        else $error("enable does not follow its term");

    a_pin_polarity: assert property (@(posedge clock_i) disable iff (!rstn_i)
        1'b1 |=> io_pin_o == ($past(cell_val) ^ ~$past(polarity_select_bit_reg)))
        else $error("pin level ignores polarity");

    a_preset_load: assert property (@(posedge clock_i)
        disable iff (!rstn_i || shared_async_clear_term_i)
        (shared_sync_set_term_i && !preload_s) |=> mc.q == '1)
        else $error("set term did not load ones");

    a_preload_load: assert property (@(posedge clock_i)
        disable iff (!rstn_i || shared_async_clear_term_i)
        preload_s |=> mc.q == $past(io_s))
        else $error("preload did not take pin values");

    a_powerup_clear: assert property (@(posedge clock_i)
        !rstn_i |=> (mc.q == '0 || shared_async_clear_term_i) && io_oe_o == '0)
        else $error("flops not cleared at power-up");

    // only registered cells are held to the cleared level; combinational ones follow eq
    a_clear_output: assert property (@(posedge clock_i) disable iff (!rstn_i)
        shared_async_clear_term_i
        |=> (io_pin_o & $past(reg_mode_reg))
            == (~$past(polarity_select_bit_reg) & $past(reg_mode_reg)))
        else $error("cleared register shows wrong pin level");

    a_secure_blank: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (rd_take && pat_hit && secure_reg)
        |=> avs_readdata_o == 32'(pom_pkg::PAT_ONES))
        else $error("secured pattern leaked on readback");

    a_bus_answer: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (req && wait_n_reg) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("bus answer not one cycle long");

    a_wait_idle: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !req |=> avs_waitrequest_o)
        else $error("waitrequest low without a request");

    // read data must stand until the next read is taken, not only in the answer cycle
    a_rd_hold: assert property (@(posedge clock_i) disable iff (!rstn_i)
        !rd_take |=> $stable(avs_readdata_o))
        else $error("read data moved without a read");

    a_sec_sticky: assert property (@(posedge clock_i) disable iff (!rstn_i)
        secure_reg |=> secure_reg)
        else $error("security bit cleared without reset");

    a_pat_open: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (rd_take && pat_hit && !secure_reg)
        |=> avs_readdata_o == 32'($past(pat_reg[pat_idx])))
        else $error("open pattern readback wrong");

    // partial-lane writes are left to the bench; here only full words are followed
    a_pol_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (wr_take && avs_address_i == pom_pkg::A_POL && avs_byteenable_i == 4'hf)
        |=> polarity_select_bit_reg == $past(avs_writedata_i[pom_pkg::N_OUT-1:0]))
        else $error("polarity write lost");

    a_mode_write: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (wr_take && avs_address_i == pom_pkg::A_MODE && avs_byteenable_i == 4'hf)
        |=> reg_mode_reg == $past(avs_writedata_i[pom_pkg::N_OUT-1:0]))
        else $error("mode write lost");

    a_pin_reset: assert property (@(posedge clock_i)
        !rstn_i |=> io_pin_o == '0)
        else $error("pins not cleared by power-up reset");

    a_stat_preload: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (rd_take && avs_address_i == pom_pkg::A_STAT)
        |=> avs_readdata_o[pom_pkg::ST_PRE_BIT] == $past(preload_s))
        else $error("status does not show preload");

    // a combinational cell read back here is how software sees it used as an input
    a_pin_read: assert property (@(posedge clock_i) disable iff (!rstn_i)
        (rd_take && avs_address_i == pom_pkg::A_PIN)
        |=> avs_readdata_o[pom_pkg::N_OUT-1:0] == $past(io_s))
        else $error("pin readback wrong");

endmodule : pom_top

// ---- common/pom_pkg.sv ----
// shared constants for the programmable output macrocell block
package pom_pkg;

    localparam int N_OUT = 10;
    localparam int N_IN = 12;
    localparam int N_LIT = 22;
    localparam int N_SYNC = 23;
    localparam int PAT_WORDS = 20;
    localparam int PAT_IW = 5;

    // register byte offsets
    localparam logic [7:0] A_POL = 8'h00;
    localparam logic [7:0] A_MODE = 8'h04;
    localparam logic [7:0] A_SEC = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0c;
    localparam logic [7:0] A_PIN = 8'h10;
    localparam logic [7:0] A_PAT = 8'h40;
    localparam logic [7:0] A_PAT_END = 8'h90;

    // field positions
    localparam int SEC_BIT = 0;
    localparam int ST_PRE_BIT = 16;
    localparam int PIN_IN_LSB = 16;

    // reset values: all outputs active-high and registered
    localparam logic [N_OUT-1:0] POL_RST = 10'h3ff;
    localparam logic [N_OUT-1:0] MODE_RST = 10'h3ff;
    localparam logic [N_LIT-1:0] PAT_RST = 22'h000000;
    localparam logic [N_LIT-1:0] PAT_ONES = 22'h3fffff;
    localparam logic [31:0] RD_ZERO = 32'h00000000;

endpackage : pom_pkg

// ---- common/pom_mc_if.sv ----
// bundle between the top level and the shared output register bank
`timescale 1ns/100ps
interface pom_mc_if;
    logic ar;
    logic sp;
    logic preload;
    logic [pom_pkg::N_OUT-1:0] eq;
    logic [pom_pkg::N_OUT-1:0] pin;
    logic [pom_pkg::N_OUT-1:0] q;

    modport core (input ar, input sp, input preload, input eq, input pin, output q);
    modport ctrl (output ar, output sp, output preload, output eq, output pin, input q);
endinterface : pom_mc_if

// ---- rtl/pom_oreg.sv ----
// bank of output flip-flops with shared preset, clear and preload
`timescale 1ns/100ps
module pom_oreg (
    input wire logic clock_i, // single device clock
    input wire logic rstn_i,  // power-up clear, active low
    pom_mc_if.core m          // terms, pins and flop state
);

    // the clear term is a shared async term, so it sits in the sensitivity list
    always_ff @(posedge clock_i or posedge m.ar) begin
        if (m.ar) begin
            m.q <= '0;
        end else if (!rstn_i) begin
            m.q <= '0;
        end else if (m.preload) begin
            m.q <= m.pin;
        end else if (m.sp) begin
            m.q <= '1;
        end else begin
            m.q <= m.eq;
        end
    end

    a_clear_wins: assert property (@(posedge clock_i)
        m.ar |-> m.q == '0)
        else $error("clear term high but flops not zero");

endmodule : pom_oreg

// ---- dv/pom_tester.sv ----
// tester model: preload sequencing and resolution of the output pin wires
`timescale 1ns/100ps
module pom_tester (
    input wire logic clock_i,                         // device clock
    input wire logic req_i,                           // hold preload while high
    input wire logic [pom_pkg::N_OUT-1:0] val_i,      // state to preload
    input wire logic [pom_pkg::N_OUT-1:0] reg_mask_i, // registered pins
    input wire logic [pom_pkg::N_OUT-1:0] ext_drv_i,  // pins driven in normal mode
    input wire logic [pom_pkg::N_OUT-1:0] ext_val_i,  // level on driven pins
    input wire logic [pom_pkg::N_OUT-1:0] dut_pin_i,  // device pin drive
    input wire logic [pom_pkg::N_OUT-1:0] dut_oe_i,   // device pin enable
    output logic [pom_pkg::N_OUT-1:0] pin_o,          // resolved pin level
    output logic hv_o,                                // super-level on preload pin
    output logic valid_o                              // outputs may be trusted
);
    logic drv;
    logic [pom_pkg::N_OUT-1:0] last = '0;
    logic [pom_pkg::N_OUT-1:0] driven;

    initial begin
        hv_o = 1'b0;
        drv = 1'b0;
        valid_o = 1'b1;
    end

    // no pull on these pins: a released pin shows the inverse of its last driven level
    always_comb begin
        driven = '0;
        pin_o = '0;
        for (int i = 0; i < pom_pkg::N_OUT; i++) begin
            driven[i] = 1'b1;
            if (dut_oe_i[i]) pin_o[i] = dut_pin_i[i];
            else if (drv && reg_mask_i[i]) pin_o[i] = val_i[i];
            else if (ext_drv_i[i] && !hv_o) pin_o[i] = ext_val_i[i];
            else begin
                driven[i] = 1'b0;
                pin_o[i] = ~last[i];
            end
        end
    end

    // only a driven level is remembered, so a floating pin holds still
    always @(posedge clock_i) last <= (pin_o & driven) | (last & ~driven);

    always begin
        do @(posedge clock_i); while (!req_i);
        hv_o <= 1'b1;
        drv <= 1'b1;
        valid_o <= 1'b0;
        do @(posedge clock_i); while (req_i);
        drv <= 1'b0;
        @(posedge clock_i);
        hv_o <= 1'b0;
        repeat (2) @(posedge clock_i); // 100 ns at 20 MHz
        valid_o <= 1'b1;
    end
endmodule : pom_tester

// ---- dv/pom_top_tb.sv ----
// self-checking bench for the output macrocell block
`timescale 1ns/100ps
module pom_top_tb;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [7:0] adr = 8'h00;
    logic rd_req = 1'b0;
    logic wr_req = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata;
    logic waitreq;
    logic [11:0] in_pin = 12'h000;
    logic [9:0] pin_lvl;
    logic [9:0] pin_drv;
    logic [9:0] oe;
    logic hv;
    logic [9:0] eq = 10'h000;
    logic set_t = 1'b0;
    logic clr_t = 1'b0;
    logic req = 1'b0;
    logic valid;
    logic [9:0] ext_drv = 10'h000;
    logic [9:0] ext_val = 10'h000;
    logic [9:0] mode = 10'h3ff;
    logic [9:0] pol = 10'h3ff;
    logic [31:0] rd;
    logic [3:0] be = 4'hf;
    int n_mismatch = 0;
    int checks = 0;
    int cycles = 0;

    always #25 clock_i = ~clock_i;

    pom_top dut (.clock_i(clock_i), .rstn_i(rstn_i), .avs_address_i(adr), .avs_read_i(rd_req),
        .avs_write_i(wr_req), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .in_pin_i(in_pin),
        .io_pin_i(pin_lvl), .io_pin_o(pin_drv), .io_oe_o(oe), .preload_hv_i(hv), .eq_i(eq),
        .shared_sync_set_term_i(set_t), .shared_async_clear_term_i(clr_t));

    pom_tester tester (.clock_i(clock_i), .req_i(req), .val_i(10'h2a5), .reg_mask_i(mode),
        .ext_drv_i(ext_drv), .ext_val_i(ext_val), .dut_pin_i(pin_drv), .dut_oe_i(oe),
        .pin_o(pin_lvl), .hv_o(hv), .valid_o(valid));

    task print_verdict;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // one access: request held until waitrequest is sampled low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock_i);
        adr <= a;
        wdata <= d;
        rd_req <= !wr;
        wr_req <= wr;
        do begin
            @(posedge clock_i);
            n++;
        end while (waitreq !== 1'b0 && n < 20);
        rd = rdata;
        rd_req <= 1'b0;
        wr_req <= 1'b0;
        if (n >= 20) chk("bus answer", 32'h1, 32'h0);
    endtask : bus

    task rdchk(input string what, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(what, rd & m, e);
    endtask : rdchk

    // two sync stages plus the output stage
    task settle;
        repeat (4) @(posedge clock_i);
    endtask : settle

    function logic [9:0] pins(input logic [9:0] q);
        return ((q & mode) | (eq & ~mode)) ^ ~pol;
    endfunction : pins

    // ceiling well above the roughly 120 cycles the sequence needs
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    initial begin
        repeat (3) @(posedge clock_i); // inputs stand still before the first edge
        rstn_i <= 1'b1;
        rdchk("pol reset", pom_pkg::A_POL, '1, 32'h3ff);
        rdchk("mode reset", pom_pkg::A_MODE, '1, 32'h3ff);
        rdchk("sec reset", pom_pkg::A_SEC, '1, 32'h0);
        rdchk("flops reset", pom_pkg::A_STAT, '1, 32'h0);
        rdchk("unmapped", 8'h20, '1, 32'h0);
        chk("oe reset", oe, 32'h0);
        chk("pins reset", pin_drv, pins(10'h000));
        mode = 10'h3fd;
        bus(1'b1, pom_pkg::A_MODE, {22'h0, mode});
        // out0 enabled by input 0, out2 by its own feedback
        bus(1'b1, pom_pkg::A_PAT, 32'h1);
        bus(1'b1, pom_pkg::A_PAT + 8'h04, 32'h1);
        bus(1'b1, pom_pkg::A_PAT + 8'h10, 32'h4000);
        bus(1'b1, pom_pkg::A_PAT + 8'h14, 32'h4000);
        rdchk("pattern", pom_pkg::A_PAT + 8'h10, '1, 32'h4000);
        eq <= 10'h157;
        in_pin <= 12'h001;
        settle();
        chk("oe terms on", oe, 32'h005);
        chk("pins high", pin_drv, pins(10'h157));
        eq <= 10'h150;
        in_pin <= 12'h000;
        settle();
        chk("oe terms off", oe, 32'h0);
        for (int v = 0; v < 2; v++) begin
            ext_drv <= 10'h002;
            ext_val <= {8'h00, v[0], 1'b0};
            settle();
            rdchk("pin as input", pom_pkg::A_PIN, 32'h2, {30'h0, v[0], 1'b0});
            chk("input pin idle", oe[1], 32'h0);
        end
        ext_drv <= 10'h000;
        pol = 10'h0f0;
        bus(1'b1, pom_pkg::A_POL, {22'h0, pol});
        // upper lanes hold no polarity bits, so this write must change nothing
        be <= 4'hc;
        bus(1'b1, pom_pkg::A_POL, 32'h0);
        be <= 4'hf;
        rdchk("pol lanes", pom_pkg::A_POL, '1, 32'h0f0);
        settle();
        chk("pins mixed", pin_drv, pins(10'h150));
        eq <= 10'h000;
        set_t <= 1'b1;
        settle();
        rdchk("set flops", pom_pkg::A_STAT, 32'h3ff, 32'h3ff);
        chk("set pins", pin_drv, pins(10'h3ff));
        clr_t <= 1'b1;
        @(negedge clock_i);
        chk("clear at once", dut.mc.q, 32'h0);
        settle();
        rdchk("clear wins", pom_pkg::A_STAT, 32'h3ff, 32'h0);
        chk("clear pins", pin_drv, pins(10'h000));
        clr_t <= 1'b0;
        in_pin <= 12'h001;
        settle();
        chk("oe before preload", oe, 32'h005);
        req <= 1'b1;
        settle();
        settle();
        chk("preload oe", oe, 32'h0);
        rdchk("preload flops", pom_pkg::A_STAT, 32'h103fd, 32'h102a5);
        set_t <= 1'b0;
        req <= 1'b0;
        for (int n = 0; n < 20 && valid !== 1'b0; n++) @(posedge clock_i);
        for (int n = 0; n < 20 && valid !== 1'b1; n++) @(posedge clock_i);
        chk("tester valid", valid, 32'h1);
        settle();
        chk("oe after preload", oe, 32'h001);
        bus(1'b1, pom_pkg::A_SEC, 32'h1);
        rdchk("secured", pom_pkg::A_SEC, 32'h1, 32'h1);
        rdchk("hidden first", pom_pkg::A_PAT, '1, 32'h003fffff);
        rdchk("hidden last", pom_pkg::A_PAT_END - 8'h04, '1, 32'h003fffff);
        print_verdict();
    end
endmodule : pom_top_tb
